/* File: pkg/pin_cfg_cfg.svh */
// Constants for the pin function and pad configuration block
`ifndef PIN_CFG_CFG_SVH
`define PIN_CFG_CFG_SVH
`define PINCFG_BASE       32'h4004_4000
`define PINCFG_OFS_P2_6   8'h00
`define PINCFG_OFS_RSVD4  8'h04
`define PINCFG_OFS_P2_0   8'h08
`define PINCFG_OFS_RST0_0 8'h0C
`define PINCFG_W          10
`define PINCFG_RST        10'h0D0
`define PINCFG_FUNCTION_SELECT_FIELD_LSB   0
`define PINCFG_FUNCTION_SELECT_FIELD_MSB   2
`define PINCFG_MODE_LSB   3
`define PINCFG_MODE_MSB   4
`define PINCFG_HYS_BIT    5
`define PINCFG_DIG_BIT    7
`define PINCFG_I2C_LSB    8
`define PINCFG_I2C_MSB    9
`define PINCFG_FIXED_MASK 10'h3C0
`define PINCFG_ANA_MASK   10'h080
`define PINCFG_I2CM_MASK  10'h300
`define PINCFG_FUNCTION_SELECT_FIELD_GPIO  3'h0
`endif

/* File: pkg/pin_cfg_pkg.sv */
// Types for the pin function and pad configuration block
`default_nettype none
package pin_cfg_pkg;
  typedef enum logic [1:0] {
    PULL_NONE   = 2'h0,
    PULL_DOWN   = 2'h1,
    PULL_UP     = 2'h2,
    PULL_REPEAT = 2'h3
  } pull_mode_t;
  typedef enum logic [1:0] {
    I2C_STD_FAST = 2'h0,
    I2C_PLAIN_IO = 2'h1,
    I2C_FAST_PLS = 2'h2,
    I2C_RSVD     = 2'h3
  } i2c_mode_t;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'h0,
    BUS_ACK  = 1'h1
  } bus_state_t;
endpackage : pin_cfg_pkg
`default_nettype wire

/* File: rtl/pin_function_and_pad_config.sv */
// Pin routing and pad control with an Avalon-MM register slave
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "pin_cfg_cfg.svh"
module pin_function_and_pad_config #(
  parameter int NUM_PINS = 3,
  parameter int NUM_FUNCTION_SELECT_FIELD = 8,
  parameter logic [2:0] ANALOG_CAP = 3'h0,
  parameter logic [2:0] I2C_CAP    = 3'h0,
  parameter logic [2:0] PIN_USED   = 3'h7,
  parameter logic       HAS_USB    = 1'h1,
  parameter logic [23:0] USB_FUNCS = 24'h00_0000
) (
  input  wire logic                               clock_i,
  input  wire logic                               nrst_i,
  input  wire logic [7:0]                         avs_address_i,
  input  wire logic                               avs_read_i,
  input  wire logic                               avs_write_i,
  input  wire logic [3:0]                         avs_byteenable_i,
  input  wire logic [31:0]                        avs_writedata_i,
  output logic [31:0]                             avs_readdata_o,
  output logic                                    avs_waitrequest_o,
  input  wire logic [NUM_PINS-1:0]                gpio_out_i,
  input  wire logic [NUM_PINS-1:0]                port_direction_i,
  input  wire logic [NUM_PINS-1:0][NUM_FUNCTION_SELECT_FIELD-1:0]  periph_out_i,
  input  wire logic [NUM_PINS-1:0][NUM_FUNCTION_SELECT_FIELD-1:0]  periph_oe_i,
  input  wire logic [NUM_PINS-1:0]                pad_in_i,
  input  wire logic                               deep_pd_i,
  output logic [NUM_PINS-1:0]                     pad_out_o,
  output logic [NUM_PINS-1:0]                     pad_oe_o,
  output logic [NUM_PINS-1:0]                     pad_pu_o,
  output logic [NUM_PINS-1:0]                     pad_pd_o,
  output logic [NUM_PINS-1:0]                     pad_hys_o,
  output logic [NUM_PINS-1:0]                     pad_rx_en_o,
  output logic [NUM_PINS-1:0]                     pad_od_o,
  output logic [NUM_PINS-1:0]                     pad_filt_o,
  output logic [NUM_PINS-1:0]                     pad_hisink_o,
  output logic [NUM_PINS-1:0]                     gpio_in_o,
  output logic [NUM_PINS-1:0]                     periph_in_o
);
  import pin_cfg_pkg::*;

  localparam int CW = `PINCFG_W;

  if (NUM_PINS != 3) begin : g_chk_pins
    $error("Address map holds exactly three pin words");
  end
  if (NUM_FUNCTION_SELECT_FIELD != 8) begin : g_chk_function_select_field
    $error("Function field is three bits wide");
  end

  // Bus slave state
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        req;
  logic        wr_take;
  logic [1:0]  pin_hit;
  logic        hit;

  logic [NUM_PINS-1:0][CW-1:0] cfg_q;
  logic [NUM_PINS-1:0][CW-1:0] cfg_d;

  assign req     = avs_read_i | avs_write_i;
  // Write lands only on the edge where waitrequest is low
  assign wr_take = avs_write_i & ~wait_q;

  always_comb begin
    pin_hit = 2'h0;
    hit     = 1'b0;
    case (avs_address_i)
      `PINCFG_OFS_P2_6: begin
        pin_hit = 2'h0;
        hit     = PIN_USED[0];
      end
      `PINCFG_OFS_P2_0: begin
        pin_hit = 2'h1;
        hit     = PIN_USED[1];
      end
      `PINCFG_OFS_RST0_0: begin
        pin_hit = 2'h2;
        hit     = PIN_USED[2];
      end
      default: begin
        pin_hit = 2'h0;
        hit     = 1'b0;
      end
    endcase
  end

  // One wait cycle on every access, then a single acknowledge cycle
  always_comb begin
    wait_d  = ~(req & wait_q);
    rdata_d = rdata_q;
    if (avs_read_i & wait_q) begin
      rdata_d = hit ? {{(32-CW){1'b0}}, cfg_q[pin_hit]} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // Configuration words
  always_comb begin
    logic [CW-1:0] wmask;
    logic [CW-1:0] fixed;
    logic [CW-1:0] byte_m;
    logic [CW-1:0] nxt;
    logic [2:0]    fsel;
    wmask  = '0;
    fixed  = '0;
    byte_m = '0;
    nxt    = '0;
    fsel   = '0;
    cfg_d  = cfg_q;
    for (int i = 0; i < NUM_PINS; i++) begin
      // Reserved and absent fields hold their reset value
      fixed = `PINCFG_FIXED_MASK;
      if (ANALOG_CAP[i]) begin
        fixed = fixed & ~`PINCFG_ANA_MASK;
      end
      if (I2C_CAP[i]) begin
        fixed = fixed & ~`PINCFG_I2CM_MASK;
      end
      byte_m = {{2{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      wmask  = byte_m & ~fixed;
      nxt    = (cfg_q[i] & ~wmask) | (avs_writedata_i[CW-1:0] & wmask);
      fsel   = nxt[`PINCFG_FUNCTION_SELECT_FIELD_MSB:`PINCFG_FUNCTION_SELECT_FIELD_LSB];
      // Without the USB controller its function codes are dead
      if (!HAS_USB && USB_FUNCS[i*NUM_FUNCTION_SELECT_FIELD + int'(fsel)]) begin
        nxt[`PINCFG_FUNCTION_SELECT_FIELD_MSB:`PINCFG_FUNCTION_SELECT_FIELD_LSB] = cfg_q[i][`PINCFG_FUNCTION_SELECT_FIELD_MSB:`PINCFG_FUNCTION_SELECT_FIELD_LSB];
      end
      if (wr_take && hit && (int'(pin_hit) == i)) begin
        cfg_d[i] = nxt;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_q[i] <= `PINCFG_RST;
      end
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Pad controls
  logic [NUM_PINS-1:0] out_d;
  logic [NUM_PINS-1:0] oe_d;
  logic [NUM_PINS-1:0] pu_d;
  logic [NUM_PINS-1:0] pd_d;
  logic [NUM_PINS-1:0] hys_d;
  logic [NUM_PINS-1:0] rx_d;
  logic [NUM_PINS-1:0] od_d;
  logic [NUM_PINS-1:0] filt_d;
  logic [NUM_PINS-1:0] sink_d;
  logic [NUM_PINS-1:0] gin_d;
  logic [NUM_PINS-1:0] pin_d;

  always_comb begin
    logic [2:0]  function_select_field;
    logic        gpio;
    logic        analog;
    logic        dout;
    logic        doe;
    pull_mode_t  pull;
    i2c_mode_t   i2cm;
    function_select_field   = '0;
    gpio   = 1'b0;
    analog = 1'b0;
    dout   = 1'b0;
    doe    = 1'b0;
    pull   = PULL_NONE;
    i2cm   = I2C_STD_FAST;
    for (int i = 0; i < NUM_PINS; i++) begin
      function_select_field   = cfg_q[i][`PINCFG_FUNCTION_SELECT_FIELD_MSB:`PINCFG_FUNCTION_SELECT_FIELD_LSB];
      gpio   = (function_select_field == `PINCFG_FUNCTION_SELECT_FIELD_GPIO);
      analog = ANALOG_CAP[i] & ~cfg_q[i][`PINCFG_DIG_BIT];
      pull   = pull_mode_t'(cfg_q[i][`PINCFG_MODE_MSB:`PINCFG_MODE_LSB]);
      i2cm   = i2c_mode_t'(cfg_q[i][`PINCFG_I2C_MSB:`PINCFG_I2C_LSB]);
      // Function code indexes the pin's function list directly
      dout = gpio ? gpio_out_i[i] : periph_out_i[i][function_select_field];
      doe  = gpio ? port_direction_i[i] : periph_oe_i[i][function_select_field];
      case (pull)
        PULL_UP: begin
          pu_d[i] = 1'b1;
          pd_d[i] = 1'b0;
        end
        PULL_DOWN: begin
          pu_d[i] = 1'b0;
          pd_d[i] = 1'b1;
        end
        PULL_REPEAT: begin
          // Keeper releases in deep power-down; the level is lost there
          pu_d[i] = pad_in_i[i] & ~deep_pd_i;
          pd_d[i] = ~pad_in_i[i] & ~deep_pd_i;
        end
        default: begin
          pu_d[i] = 1'b0;
          pd_d[i] = 1'b0;
        end
      endcase
      if (analog) begin
        pu_d[i] = 1'b0;
        pd_d[i] = 1'b0;
      end
      hys_d[i] = cfg_q[i][`PINCFG_HYS_BIT] & ~analog;
      rx_d[i]  = ~analog;
      od_d[i]   = I2C_CAP[i];
      filt_d[i] = I2C_CAP[i] & ((i2cm == I2C_STD_FAST) | (i2cm == I2C_FAST_PLS));
      sink_d[i] = I2C_CAP[i] & (i2cm == I2C_FAST_PLS);
      // Open-drain pads only ever drive low
      if (I2C_CAP[i]) begin
        out_d[i] = 1'b0;
        oe_d[i]  = doe & ~dout;
      end else begin
        out_d[i] = dout;
        oe_d[i]  = doe;
      end
      gin_d[i] = gpio & ~analog & pad_in_i[i];
      pin_d[i] = ~gpio & ~analog & pad_in_i[i];
    end
  end

  // Registered pads: a write shows one edge after it lands
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pad_out_o    <= '0;
      pad_oe_o     <= '0;
      pad_pu_o     <= '0;
      pad_pd_o     <= '0;
      pad_hys_o    <= '0;
      pad_rx_en_o  <= '0;
      pad_od_o     <= '0;
      pad_filt_o   <= '0;
      pad_hisink_o <= '0;
      gpio_in_o    <= '0;
      periph_in_o  <= '0;
    end else begin
      pad_out_o    <= out_d;
      pad_oe_o     <= oe_d;
      pad_pu_o     <= pu_d;
      pad_pd_o     <= pd_d;
      pad_hys_o    <= hys_d;
      pad_rx_en_o  <= rx_d;
      pad_od_o     <= od_d;
      pad_filt_o   <= filt_d;
      pad_hisink_o <= sink_d;
      gpio_in_o    <= gin_d;
      periph_in_o  <= pin_d;
    end
  end

  // Checks on pin 0, the reserved word and waitrequest
  chk_gpio_dir: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ($past(cfg_q[0][2:0]) == 3'h0 && !I2C_CAP[0]) |-> pad_oe_o[0] == $past(port_direction_i[0]))
    else $error("GPIO direction not from port direction");

  chk_periph_dir: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ($past(cfg_q[0][2:0]) != 3'h0 && !I2C_CAP[0]) |->
      pad_oe_o[0] == $past(periph_oe_i[0][cfg_q[0][2:0]]))
    else $error("Peripheral direction not followed");

  chk_pullup_reset: assert property (@(posedge clock_i)
    $rose(nrst_i) |-> cfg_q[0][4:3] == 2'h2)
    else $error("Pull field not pull-up after reset");

  chk_repeater_lvl: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ($past(cfg_q[0][4:3]) == 2'h3 && !$past(deep_pd_i) && !ANALOG_CAP[0]) |->
      (pad_pu_o[0] == $past(pad_in_i[0])) && (pad_pd_o[0] == !$past(pad_in_i[0])))
    else $error("Repeater does not follow pin level");

  chk_deep_pd: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ($past(cfg_q[0][4:3]) == 2'h3 && $past(deep_pd_i)) |-> !pad_pu_o[0] && !pad_pd_o[0])
    else $error("Repeater active in deep power-down");

  chk_hys_select: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !ANALOG_CAP[0] |=> pad_hys_o[0] == $past(cfg_q[0][5]))
    else $error("Hysteresis not from its bit");

  chk_rsvd_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (avs_read_i && wait_q && avs_address_i == `PINCFG_OFS_RSVD4) |=> avs_readdata_o == 32'h0000_0000)
    else $error("Reserved word reads nonzero");

  chk_write_lat: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (wr_take && avs_address_i == `PINCFG_OFS_P2_6 && avs_byteenable_i[0] && !I2C_CAP[0] && !ANALOG_CAP[0]) |=>
      ##1 pad_hys_o[0] == $past(avs_writedata_i[5], 2))
    else $error("Written word not on pads in time");

  chk_wait_one: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (req && wait_q) |=> !wait_q ##1 wait_q)
    else $error("Waitrequest not a single low cycle");

endmodule : pin_function_and_pad_config
`default_nettype wire

/* File: testbench/pad_partner.sv */
// External circuitry on the pads: drivers, pull resistors, floating lines
`timescale 1ns/100ps
`default_nettype none
module pad_partner #(
  parameter int N = 3
) (
  input  wire logic         clock_i,
  input  wire logic [N-1:0] oe_i,
  input  wire logic [N-1:0] out_i,
  input  wire logic [N-1:0] pu_i,
  input  wire logic [N-1:0] pd_i,
  input  wire logic [N-1:0] ext_en_i,
  input  wire logic [N-1:0] ext_val_i,
  output logic      [N-1:0] pad_o
);
  logic [N-1:0] float_q = '0;
  // Undriven, unpulled line wanders each cycle, so a stale level never passes
  always_ff @(posedge clock_i) begin
    float_q <= ~float_q;
  end
  // Device driver wins over the external one
  always_comb begin
    pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | (~pd_i & float_q)));
  end
endmodule : pad_partner
`default_nettype wire

/* File: testbench/pin_function_and_pad_config_tb.sv */
// Self-checking bench for the pin configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module pin_function_and_pad_config_tb;
  import pin_cfg_pkg::*;
  logic            clock_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic            deep_pd_i = 0, lite_wait;
  logic [7:0]      avs_address_i = '0;
  logic [31:0]     avs_writedata_i = '0, avs_readdata_o, q;
  logic [31:0]     lite_rdata, q2;
  logic [2:0]      gpio_out_i = '0, port_direction_i = '0, ext_en = '0, ext_val = '0, pad_in_i;
  logic [2:0][7:0] periph_out_i = '0, periph_oe_i = '0;
  logic [2:0]      pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o, pad_hys_o, pad_rx_en_o, pad_od_o, pad_filt_o;
  logic [2:0]      pad_hisink_o, gpio_in_o, periph_in_o;
  logic [9:0]      wd;
  int              error_cnt = 0, n_tests = 0, seed = 58;

  pin_function_and_pad_config #(.ANALOG_CAP(3'h2), .I2C_CAP(3'h4)) u_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .gpio_out_i(gpio_out_i),
    .port_direction_i(port_direction_i), .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
    .pad_in_i(pad_in_i), .deep_pd_i(deep_pd_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o),
    .pad_pd_o(pad_pd_o), .pad_hys_o(pad_hys_o), .pad_rx_en_o(pad_rx_en_o), .pad_od_o(pad_od_o),
    .pad_filt_o(pad_filt_o), .pad_hisink_o(pad_hisink_o), .gpio_in_o(gpio_in_o), .periph_in_o(periph_in_o));

  // Variant without USB controller, third pin absent; shares the bus, answers in step
  pin_function_and_pad_config #(.HAS_USB(1'h0), .USB_FUNCS(24'h00_0008), .PIN_USED(3'h3)) u_dut_lite (
    .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(lite_rdata), .avs_waitrequest_o(lite_wait), .gpio_out_i(gpio_out_i),
    .port_direction_i(port_direction_i), .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
    .pad_in_i(pad_in_i), .deep_pd_i(deep_pd_i), .pad_out_o(), .pad_oe_o(), .pad_pu_o(), .pad_pd_o(),
    .pad_hys_o(), .pad_rx_en_o(), .pad_od_o(), .pad_filt_o(), .pad_hisink_o(), .gpio_in_o(), .periph_in_o());

  pad_partner #(.N(3)) u_pads (
    .clock_i(clock_i), .oe_i(pad_oe_o), .out_i(pad_out_o), .pu_i(pad_pu_o), .pd_i(pad_pd_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in_i));

  initial begin
    forever #4 clock_i = ~clock_i;
  end

  // Idle edge first, so a strobe is never lowered and raised in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0 || lite_wait !== 1'b0);
    q = avs_readdata_o;
    q2 = lite_rdata;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  // Pin 0 pads as {out, oe, pu, pd, hys, rx_en}
  function automatic logic [5:0] exp_pads(input logic [9:0] w);
    logic [2:0] f;
    f = w[2:0];
    return {f == 3'h0 ? gpio_out_i[0] : periph_out_i[0][f], f == 3'h0 ? port_direction_i[0] : periph_oe_i[0][f],
            w[4:3] == PULL_UP, w[4:3] == PULL_DOWN, w[5], 1'b1};
  endfunction : exp_pads

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask : test_end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge clock_i);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    `CHK("reset pull", 3'h7, pad_pu_o)
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK("reset word", (a == 4) ? 32'h0 : 32'hD0, q)
    end
    bus(1'b1, 8'h04, $random(seed));
    bus(1'b0, 8'h04, 32'h0);
    `CHK("reserved word", 32'h0, q)
    bus(1'b1, 8'h00, 32'h3D0);
    bus(1'b0, 8'h00, 32'h0);
    `CHK("i2c bits off", 32'hD0, q)
    test_end("reset");
    // Supply taken as 2.5 V or more, so hysteresis may be set
    for (int i = 0; i < 24; i++) begin
      gpio_out_i <= 3'($random(seed));
      port_direction_i <= 3'($random(seed));
      periph_out_i <= 24'($random(seed));
      periph_oe_i <= 24'($random(seed));
      wd = 10'($random(seed)) & 10'h03F;
      if (wd[4:3] == 2'h3) wd[4:3] = 2'h2;
      if (i < 2) wd[2:0] = i ? 3'h7 : 3'h0;
      bus(1'b1, 8'h00, {22'h0, wd});
      repeat (2) @(posedge clock_i);
      `CHK("pin0 pads", exp_pads(wd), ({pad_out_o[0], pad_oe_o[0], pad_pu_o[0], pad_pd_o[0], pad_hys_o[0], pad_rx_en_o[0]}))
      bus(1'b0, 8'h00, 32'h0);
      `CHK("pin0 word", {22'h0, 4'h3, wd[5:0]}, q)
    end
    test_end("routing");
    port_direction_i <= 3'h0;
    bus(1'b1, 8'h00, 32'hD8);
    for (int v = 1; v >= 0; v--) begin
      ext_val <= 3'(v);
      ext_en <= 3'h1;
      repeat (3) @(posedge clock_i);
      ext_en <= 3'h0;
      repeat (4) @(posedge clock_i);
      `CHK("keeper", (v ? 3'h5 : 3'h2), ({pad_pu_o[0], pad_pd_o[0], gpio_in_o[0]}))
    end
    deep_pd_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    `CHK("deep keeper", 2'h0, ({pad_pu_o[0], pad_pd_o[0]}))
    deep_pd_i <= 1'b0;
    test_end("repeater");
    periph_oe_i <= '0;
    bus(1'b1, 8'h00, 32'h0D1);
    ext_en <= 3'h1;
    for (int v = 0; v < 2; v++) begin
      ext_val <= 3'(v);
      repeat (3) @(posedge clock_i);
      `CHK("periph input", 2'(v), ({gpio_in_o[0], periph_in_o[0]}))
    end
    ext_en <= 3'h0;
    test_end("periph input");
    bus(1'b1, 8'h08, 32'h030);
    repeat (2) @(posedge clock_i);
    `CHK("analog pads", 4'h0, ({pad_pu_o[1], pad_pd_o[1], pad_hys_o[1], pad_rx_en_o[1]}))
    bus(1'b0, 8'h08, 32'h0);
    `CHK("analog word", 32'h070, q)
    test_end("analog");
    for (int m = 0; m < 3; m++) begin
      wd = {2'(m), (m == 1) ? 8'hD0 : 8'hD1};
      bus(1'b1, 8'h0C, {22'h0, wd});
      repeat (2) @(posedge clock_i);
      `CHK("i2c pads", ({1'b1, m != 1, m == 2}), ({pad_od_o[2], pad_filt_o[2], pad_hisink_o[2]}))
    end
    test_end("i2c");
    bus(1'b1, 8'h00, 32'h0D0);
    bus(1'b1, 8'h00, 32'h0CB);
    bus(1'b0, 8'h00, 32'h0);
    `CHK("usb code kept", 32'h0C8, q2)
    `CHK("usb code full", 32'h0CB, q)
    bus(1'b1, 8'h0C, 32'h0D1);
    bus(1'b0, 8'h0C, 32'h0);
    `CHK("unused word", 32'h0, q2)
    `CHK("used word", 32'h0D1, q)
    test_end("variants");
    conclude();
  end
endmodule : pin_function_and_pad_config_tb
`default_nettype wire
